// ===== sram_ctl_pkg.sv
package sram_ctl_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 8;

  // ----------------------------------------------------------------
  // Timing figures in ns and derived counts at 40 MHz
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned T_RC_NS       = 55;  // Read cycle and address access
  localparam int unsigned T_OE_NS       = 30;  // Output enable access
  localparam int unsigned T_OHZ_NS      = 20;  // Output disable to high-z
  localparam int unsigned T_AW_NS       = 50;  // Address valid to end of write
  localparam int unsigned T_CW_NS       = 50;  // Select to end of write
  localparam int unsigned T_WP_NS       = 45;  // Write pulse width
  localparam int unsigned T_DW_NS       = 25;  // Data to write overlap
  localparam int unsigned T_WHZ_NS      = 20;  // Write to output off

  // Least times round up; one extra cycle for read covers input sampling
  localparam int unsigned RD_CYC  = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int unsigned WR_BASE = (T_AW_NS > T_WHZ_NS + T_DW_NS) ? T_AW_NS : T_WHZ_NS + T_DW_NS;
  localparam int unsigned WR_CYC  = (WR_BASE + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TA_CYC  = (T_OHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W   = 3;

  // ----------------------------------------------------------------
  // Controller states, one-bit steps only on idle-setup, setup-read and write-recover
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SETUP = 3'h1,
    ST_RD    = 3'h3,
    ST_WR    = 3'h2,
    ST_TURN  = 3'h6
  } sct_state_type;

endpackage : sram_ctl_pkg

// ===== sct_sync2.sv
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs
module sct_sync2 #(
  parameter int unsigned W = 8
) (
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_r;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // First stage feeds only the second
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule : sct_sync2

// ===== sct_host.sv
`timescale 1ns/1ps
// What this block does
// - The host holds the write strobe high during every read.
// - The host changes the address only while the memory is deselected or the write strobe is high.
// - With output enable low in a strobe-ended write, the strobe outlasts turn-off plus data overlap.
// - The host never drives the data bus while the memory may be driving it.
// - The host presents the address no later than select activation and allows 55 ns access.
// - The host holds the write address at least 50 ns before the end of write.
// - The host holds both selects active at least 50 ns before the end of write.
// - The host deselects the memory no later than entering data retention.
module sct_host (
  input  wire logic                                 clock,
  input  wire logic                                 srst,
  // User side
  input  wire logic                                 req_valid,
  input  wire logic                                 req_write,
  input  wire logic [sram_ctl_pkg::ADDR_W-1:0]      req_addr,
  input  wire logic [sram_ctl_pkg::DATA_W-1:0]      req_wdata,
  output logic                                      req_ready,
  output logic                                      rd_valid,
  output logic      [sram_ctl_pkg::DATA_W-1:0]      rd_data,
  input  wire logic                                 retain_req,
  output logic                                      retain_ok,
  // Memory pins
  output logic      [sram_ctl_pkg::ADDR_W-1:0]      word_address,
  output logic                                      select_low_active_n,
  output logic                                      select_high_active,
  output logic                                      write_strobe_n,
  output logic                                      output_enable_n,
  input  wire logic [sram_ctl_pkg::DATA_W-1:0]      data_bus_in,
  output logic      [sram_ctl_pkg::DATA_W-1:0]      data_bus_out,
  output logic                                      data_bus_oe
);

  sram_ctl_pkg::sct_state_type state_r;
  sram_ctl_pkg::sct_state_type state_nxt;
  logic [sram_ctl_pkg::CNT_W-1:0] cnt_r;
  logic [sram_ctl_pkg::CNT_W-1:0] cnt_nxt;
  logic                           is_wr_r;
  logic [sram_ctl_pkg::DATA_W-1:0] bus_sync;

  // ----------------------------------------------------------------
  // Read data synchroniser
  // ----------------------------------------------------------------
  // Memory pins are not timed to clock, so two stages before use
  sct_sync2 #(.W(sram_ctl_pkg::DATA_W)) u_sync (
    .clock (clock),
    .srst  (srst),
    .din   (data_bus_in),
    .dout  (bus_sync)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic cnt_done  = (cnt_r == '0);
  wire logic idle      = (state_r == sram_ctl_pkg::ST_IDLE);
  // Request accepted only while ready is shown to the user
  wire logic take      = idle && req_valid && req_ready && !retain_req;
  wire logic rd_finish = (state_r == sram_ctl_pkg::ST_RD) && cnt_done;
  wire logic wr_finish = (state_r == sram_ctl_pkg::ST_WR) && cnt_done;
  // Direction of the request taken now, else the one already held
  wire logic wr_cur    = take ? req_write : is_wr_r;
  // Loads are one less than the cycles spent in the state
  wire logic [sram_ctl_pkg::CNT_W-1:0] rd_load = sram_ctl_pkg::CNT_W'(sram_ctl_pkg::RD_CYC - 1);
  wire logic [sram_ctl_pkg::CNT_W-1:0] wr_load = sram_ctl_pkg::CNT_W'(sram_ctl_pkg::WR_CYC - 1);
  wire logic [sram_ctl_pkg::CNT_W-1:0] ta_load = sram_ctl_pkg::CNT_W'(sram_ctl_pkg::TA_CYC - 1);

  // Next state and counter
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_done ? cnt_r : cnt_r - 1'b1;
    case (state_r)
      sram_ctl_pkg::ST_IDLE: begin
        if (take) begin
          state_nxt = sram_ctl_pkg::ST_SETUP;
        end
      end
      sram_ctl_pkg::ST_SETUP: begin
        state_nxt = is_wr_r ? sram_ctl_pkg::ST_WR : sram_ctl_pkg::ST_RD;
        cnt_nxt   = is_wr_r ? wr_load : rd_load;
      end
      sram_ctl_pkg::ST_RD: begin
        if (rd_finish) begin
          state_nxt = sram_ctl_pkg::ST_TURN;
          cnt_nxt   = ta_load;
        end
      end
      sram_ctl_pkg::ST_WR: begin
        if (wr_finish) begin
          state_nxt = sram_ctl_pkg::ST_TURN;
          cnt_nxt   = '0;
        end
      end
      sram_ctl_pkg::ST_TURN: begin
        if (cnt_done) begin
          state_nxt = sram_ctl_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = sram_ctl_pkg::ST_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Pin drive decode
  // ----------------------------------------------------------------
  // selects held through setup and strobe
  wire logic sel_nxt = (state_nxt == sram_ctl_pkg::ST_SETUP) || (state_nxt == sram_ctl_pkg::ST_RD)
                       || (state_nxt == sram_ctl_pkg::ST_WR);
  wire logic we_nxt  = (state_nxt == sram_ctl_pkg::ST_WR);
  // output enable kept high in writes
  wire logic oe_nxt  = (state_nxt == sram_ctl_pkg::ST_RD);
  // drive bus only in write path
  wire logic drv_nxt = wr_cur && ((state_nxt == sram_ctl_pkg::ST_SETUP) || we_nxt);

  // State registers
  // Direction is latched only when a request is taken
  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= sram_ctl_pkg::ST_IDLE;
      cnt_r   <= '0;
      is_wr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (take) begin
        is_wr_r <= req_write;
      end
    end
  end

  // address loaded only while deselected
  // Write data loaded with the address so it is settled before the strobe
  always_ff @(posedge clock) begin
    if (srst) begin
      word_address <= '0;
      data_bus_out <= '0;
    end else if (take) begin
      word_address <= req_addr;
      data_bus_out <= req_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Pin registers
  // ----------------------------------------------------------------
  // selects go active with the address, never before it
  always_ff @(posedge clock) begin
    if (srst) begin
      select_low_active_n <= 1'b1;
      select_high_active  <= 1'b0;
    end else begin
      select_low_active_n <= ~sel_nxt;
      select_high_active  <= sel_nxt;
    end
  end

  // Strobe and output enable, never low together
  always_ff @(posedge clock) begin
    if (srst) begin
      write_strobe_n  <= 1'b1;
      output_enable_n <= 1'b1;
    end else begin
      write_strobe_n  <= ~we_nxt;
      output_enable_n <= ~oe_nxt;
    end
  end

  // Host drive drops with the strobe's rise, so data hold is zero
  always_ff @(posedge clock) begin
    if (srst) begin
      data_bus_oe <= 1'b0;
    end else begin
      data_bus_oe <= drv_nxt;
    end
  end

  // ----------------------------------------------------------------
  // User handshake and read capture
  // ----------------------------------------------------------------
  // Ready when the next cycle is idle and no retention is asked
  always_ff @(posedge clock) begin
    if (srst) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state_nxt == sram_ctl_pkg::ST_IDLE) && !retain_req;
    end
  end

  // One-cycle pulse with the byte taken at the end of the read
  // Data stays until the next read so a slow user can still pick it up
  always_ff @(posedge clock) begin
    if (srst) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= rd_finish;
      if (rd_finish) begin
        rd_data <= bus_sync;
      end
    end
  end

  // granted only while parked and no request is being taken
  always_ff @(posedge clock) begin
    if (srst) begin
      retain_ok <= 1'b0;
    end else begin
      retain_ok <= retain_req && idle && !take;
    end
  end

endmodule : sct_host

// ===== sct_host_sva.sv
`timescale 1ns/1ps
module sct_host_sva (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        retain_ok,
  input wire logic [19:0] word_address,
  input wire logic        select_low_active_n,
  input wire logic        select_high_active,
  input wire logic        write_strobe_n,
  input wire logic        output_enable_n,
  input wire logic        data_bus_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  AST_RD_NO_WR: assert property (!output_enable_n |-> write_strobe_n)
    else $error("strobe low in read");
  AST_ADDR_MOVE: assert property ($changed(word_address) |-> $past(write_strobe_n) &&
    ($past(select_low_active_n) || !$past(select_high_active))) else $error("address moved while armed");
  AST_NO_FIGHT: assert property (!output_enable_n |-> !data_bus_oe)
    else $error("host drives during read");
  AST_WR_OE: assert property (!write_strobe_n |-> output_enable_n && data_bus_oe)
    else $error("write without data or with output on");
  AST_WR_ADDR: assert property ($rose(write_strobe_n) |-> !$past(write_strobe_n, 2) &&
    word_address == $past(word_address, 2)) else $error("write address too short");
  AST_WR_SEL: assert property ($fell(write_strobe_n) |->
    (!select_low_active_n && select_high_active)[*2]) else $error("selects short in write");
  AST_RD_SETUP: assert property ($fell(output_enable_n) |-> !$past(select_low_active_n) &&
    $stable(word_address) ##1 (!output_enable_n)[*2]) else $error("read setup or length wrong");
  AST_RETAIN: assert property (retain_ok |-> select_low_active_n && !select_high_active)
    else $error("selected while retained");
  COV_WR: cover property ($rose(write_strobe_n));
  COV_RD: cover property ($fell(output_enable_n));
  COV_RET: cover property ($rose(retain_ok));
endmodule : sct_host_sva
bind sct_host sct_host_sva i_sva (.clock, .srst, .retain_ok, .word_address, .select_low_active_n,
  .select_high_active, .write_strobe_n, .output_enable_n, .data_bus_oe);

// ===== sct_mem_model.sv
`timescale 1ns/1ps
module sct_mem_model #(
  parameter int RD_DLY = 30
) (
  input  wire logic [19:0] word_address,
  input  wire logic        select_low_active_n,
  input  wire logic        select_high_active,
  input  wire logic        write_strobe_n,
  input  wire logic        output_enable_n,
  input  wire logic [7:0]  data_bus_out,
  input  wire logic        data_bus_oe,
  output logic      [7:0]  data_bus_in
);
  logic [7:0] mem [0:1048575];
  logic [7:0] junk = 8'h5a;
  logic [7:0] rd_word;
  logic       drv_late;
  wire        sel = !select_low_active_n && select_high_active;
  wire        drv = sel && !output_enable_n && write_strobe_n;
  assign #(RD_DLY) drv_late = drv;
  assign #10 rd_word = mem[word_address];
  // Floating bus wanders
  always #13 junk = junk + 8'h35;
  // write on overlap, from the host drive to dodge the edge race
  always @* if (sel && !write_strobe_n && data_bus_oe) mem[word_address] = data_bus_out;
  assign data_bus_in = data_bus_oe ? data_bus_out : (drv && drv_late) ? rd_word : junk;
endmodule : sct_mem_model

// ===== test_sct_host.sv
`timescale 1ns/1ps
module test_sct_host;
  logic        clock, srst, req_valid, req_write, req_ready, rd_valid, retain_req, retain_ok;
  logic        select_low_active_n, select_high_active, write_strobe_n, output_enable_n, data_bus_oe;
  logic [19:0] req_addr, word_address;
  logic [19:0] alist [12];
  logic [7:0]  req_wdata, rd_data, data_bus_in, data_bus_out;
  logic [7:0]  shadow [int unsigned];
  int          miscompares = 0, check_count = 0, cyc = 0, n;
  sct_host i_dut (.clock, .srst, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready, .rd_valid,
    .rd_data, .retain_req, .retain_ok, .word_address, .select_low_active_n, .select_high_active,
    .write_strobe_n, .output_enable_n, .data_bus_in, .data_bus_out, .data_bus_oe);
  sct_mem_model i_mem (.word_address, .select_low_active_n, .select_high_active, .write_strobe_n,
    .output_enable_n, .data_bus_out, .data_bus_oe, .data_bus_in);
  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] want(input logic [19:0] a);
    return shadow[a];
  endfunction : want
  // One request; reads are compared on return
  task automatic op(input logic wr, input logic [19:0] a, input logic [7:0] d);
    n = 0;
    @(negedge clock);
    while (!req_ready && n < 50) begin
      @(negedge clock);
      n++;
    end
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge clock);
    req_valid = 1'b0;
    if (wr) shadow[a] = d;
    n = 0;
    while (!wr && !rd_valid && n < 20) begin
      @(negedge clock);
      n++;
    end
    if (!wr) check(20'(n), 20'(1 + sram_ctl_pkg::RD_CYC));
    if (!wr) check(20'(rd_data), 20'(want(a)));
  endtask : op
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  initial begin
    {srst, req_valid, req_write, retain_req, req_addr, req_wdata} = {4'h8, 20'h0, 8'h0};
    n = $urandom(2);
    repeat (6) @(negedge clock);
    srst = 1'b0;
    check(20'({select_low_active_n, select_high_active, write_strobe_n, output_enable_n, data_bus_oe}), 20'h16);
    op(1'b1, 20'h00000, 8'ha5);
    op(1'b1, 20'hfffff, 8'h5a);
    op(1'b1, 20'h00000, 8'h3c);
    op(1'b0, 20'h00000, 8'h00);
    op(1'b0, 20'hfffff, 8'h00);
    $display("corner test done");
    for (int i = 0; i < 12; i++) begin
      alist[i] = 20'($urandom);
      op(1'b1, alist[i], 8'($urandom));
    end
    for (int i = 11; i >= 0; i--) op(1'b0, alist[i], 8'h00);
    $display("random test done");
    retain_req = 1'b1;
    n = 0;
    while (!retain_ok && n < 20) begin
      @(negedge clock);
      n++;
    end
    check(20'(retain_ok), 20'h1);
    check(20'(req_ready), 20'h0);
    retain_req = 1'b0;
    op(1'b0, alist[0], 8'h00);
    $display("retention test done");
    test_done();
  end
endmodule : test_sct_host
